// ### common/tecm_pkg.sv
// Types shared by the timer/event counter block.
package tecm_pkg;
    // Pulse measurement sequencer, one-hot
    typedef enum logic [2:0] {
        TECM_IDLE    = 3'b001,
        TECM_ARMED   = 3'b010,
        TECM_MEASURE = 3'b100
    } tecm_pulse_e;
endpackage

// ### common/tecm_regs.svh
// Register map, field positions and reset values of the timer/event counter block.
// Overview of operation
// - Mode from control bits seven and six
// - Mode 10: count system clock divided by four
// - Mode 01: count external pin transitions
// - Mode 11: count divided clock during pulse
// - Bit four runs or halts the counter
// - Edge bit zero rising, one falling
// - Event mode: no prescaler on pin edges
// - Overflow: request, reload preload, keep counting
// - Interrupt forwarded only when enable set
// - Event counting continues in power-down, wakes
// - Pulse mode: run only arms counter
// - Edge zero: falling starts, high stops, clears
// - Edge one: rising starts, low stops, clears
// - Timer and event modes never self-clear run
// - After pulse, hold value, ignore pin
// - Pulse start needs transition, not level
// - Pull-high stays active on counter input
// - Overflow after FFH or FFFFH
// - Stopped preload write loads counter at once
// - Long low write buffered until high write
// - High read latches low byte for reads
`ifndef TECM_REGS_SVH
`define TECM_REGS_SVH

// Byte addresses on the bus
`define TECM_ADDR_SHORT_CTRL  8'h00
`define TECM_ADDR_SHORT_COUNT 8'h04
`define TECM_ADDR_LONG_CTRL   8'h08
`define TECM_ADDR_LONG_LOW    8'h0c
`define TECM_ADDR_LONG_HIGH   8'h10
`define TECM_ADDR_INT_CTRL    8'h14

// Control register fields
`define TECM_MODE_HI      7
`define TECM_MODE_LO      6
`define TECM_RUN_BIT      4
`define TECM_EDGE_BIT     3
`define TECM_CTRL_RESET   8'h00

// Mode encodings
`define TECM_MODE_EVENT   2'h1
`define TECM_MODE_TIMER   2'h2
`define TECM_MODE_PULSE   2'h3

// Interrupt control fields
`define TECM_INT_EN_SHORT  0
`define TECM_INT_EN_LONG   1
`define TECM_INT_REQ_SHORT 4
`define TECM_INT_REQ_LONG  5

// Divide by four prescaler
`define TECM_PRESCALE_LAST 2'h3

// AHB transfer type bit that marks an active transfer
`define TECM_HTRANS_ACTIVE 1

`endif

// ### dv/tecm_pin_src.sv
// Behavioural source of pulses and events on one timer input pin.
module tecm_pin_src (
    input  wire logic       core_clk,
    input  wire logic       go,     // One-cycle burst start
    input  wire logic [7:0] pulses, // Pulses per burst
    input  wire logic [7:0] width,  // Cycles in each half pulse
    input  wire logic       idle,   // Level held between bursts
    output logic            pin,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////////
    // Only this model drives the pin, the device sees it as an input
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end

    // Burst: leave idle level, come back, repeat; wide halves act as a slow source
    always @(posedge core_clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (int p = 0; p < pulses; p++) begin
                pin <= ~idle;
                repeat (width) @(posedge core_clk);
                pin <= idle;
                repeat (width) @(posedge core_clk);
            end
            busy <= 1'b0;
        end else if (!busy) begin
            pin <= idle;
        end
    end
endmodule

// ### dv/testbench.sv
// Self-checking bench for the timer/event counter block.
`include "tecm_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk = 1'b0;       // 20 MHz bus and counter clock
    logic        rst = 1'b1;            // Held for 20 cycles
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [1:0]  pins;                  // Short pin in bit 0, long in bit 1
    logic [1:0]  pullup_select = 2'h0;
    logic [1:0]  pullup_enable;
    logic        power_down = 1'b0;
    logic        short_irq;
    logic        long_irq;
    logic        wake_up;
    logic [1:0]  go = 2'h0;             // Burst starts for the sources
    logic [1:0]  idle = 2'h0;           // Pin levels between bursts
    logic [1:0]  busy;
    logic [7:0]  pulses = 8'h05;
    logic [7:0]  width = 8'h03;
    logic        rd_dphase = 1'b0;      // Read data phase under way
    logic [31:0] exp_word;
    logic [31:0] expq[$];               // Expected read data, oldest first
    int          errors = 0;
    int          checks = 0;
    int          wakes = 0;
    int          seed = 65384;

    always #25 core_clk = ~core_clk;

    tecm_top dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .short_count_pin(pins[0]), .long_count_pin(pins[1]), .pullup_select(pullup_select),
        .pullup_enable(pullup_enable), .power_down(power_down), .short_irq(short_irq), .long_irq(long_irq),
        .wake_up(wake_up));

    // One pin source per counter
    for (genvar i = 0; i < 2; i++) begin : g_src
        tecm_pin_src src (.core_clk(core_clk), .go(go[i]), .pulses(pulses), .width(width), .idle(idle[i]),
            .pin(pins[i]), .busy(busy[i]));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watcher: each read data phase takes the oldest note; also counts wake pulses
    always @(posedge core_clk) begin
        if (rd_dphase) begin
            exp_word = (expq.size() > 0) ? expq.pop_front() : 'x;
            `CHK(hrdata, exp_word)
            `CHK(hresp, 1'b0)
        end
        rd_dphase <= hsel && htrans[1] && !hwrite && hreadyout;
        if (wake_up === 1'b1) begin
            wakes++;
        end
    end

    task automatic final_report;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Bounded wait for the bus to be ready
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                errors++;
                final_report;
            end
            @(posedge core_clk);
        end
    endtask

    // Single AHB word transfer; a read notes its expected data first
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        if (!w) begin
            expq.push_back(d);
        end
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        wait_rdy;
    endtask

    function automatic logic [7:0] ca(input int ch);
        return ch ? `TECM_ADDR_LONG_CTRL : `TECM_ADDR_SHORT_CTRL;
    endfunction

    function automatic logic [31:0] cv(input logic [7:0] b, input int e);
        return {24'h0, b | 8'(e << 3)};
    endfunction

    // Counter write: long one low byte first, then high
    task automatic ld(input int ch, input logic [15:0] v);
        if (ch) begin
            xfer(`TECM_ADDR_LONG_LOW, 1'b1, {24'h0, v[7:0]});
            xfer(`TECM_ADDR_LONG_HIGH, 1'b1, {24'h0, v[15:8]});
        end else begin
            xfer(`TECM_ADDR_SHORT_COUNT, 1'b1, {24'h0, v[7:0]});
        end
    endtask

    // Counter read: long one high first to latch the low byte
    task automatic rd_cnt(input int ch, input logic [15:0] v);
        if (ch) begin
            xfer(`TECM_ADDR_LONG_HIGH, 1'b0, {24'h0, v[15:8]});
            xfer(`TECM_ADDR_LONG_LOW, 1'b0, {24'h0, v[7:0]});
        end else begin
            xfer(`TECM_ADDR_SHORT_COUNT, 1'b0, {24'h0, v[7:0]});
        end
    endtask

    // Random pull-high choice must pass through whatever the mode
    task automatic pull_chk;
        pullup_select <= 2'($random(seed));
        cyc(3);
        `CHK(pullup_enable, pullup_select)
    endtask

    // One burst from a source, bounded wait for its end
    task automatic burst(input int ch);
        int k;
        k = 0;
        go <= 2'(1 << ch);
        cyc(1);
        go <= 2'h0;
        // The source raises busy at the edge that sees go; look one edge later
        cyc(1);
        while (busy[ch] !== 1'b0 && k < 2000) begin
            k++;
            cyc(1);
        end
        if (k >= 2000) begin
            errors++;
            final_report;
        end
        cyc(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        cyc(20);
        rst <= 1'b0;
        cyc(1);
        `CHK({short_irq, long_irq, wake_up, pullup_enable}, 5'h00)
        for (int a = 0; a < 28; a += 4) begin
            xfer(8'(a), 1'b0, 32'h0);
        end
        xfer(8'h18, 1'b1, 32'hffffffff);
        xfer(8'h18, 1'b0, 32'h0);
        // Interval timing: 40 cycles of run are ten ticks, period three wraps
        for (int ch = 0; ch < 2; ch++) begin
            xfer(ca(ch), 1'b1, 32'h80);
            ld(ch, 16'hfffd);
            xfer(`TECM_ADDR_LONG_LOW, 1'b1, 32'h55);
            rd_cnt(ch, 16'hfffd);
            xfer(ca(ch), 1'b1, 32'h90);
            cyc(38);
            xfer(ca(ch), 1'b1, 32'h80);
            rd_cnt(ch, 16'hfffe);
            cyc(20);
            rd_cnt(ch, 16'hfffe);
        end
        xfer(`TECM_ADDR_INT_CTRL, 1'b0, 32'h30);
        `CHK({short_irq, long_irq, wakes}, {2'h0, 32'h0})
        xfer(`TECM_ADDR_INT_CTRL, 1'b1, 32'h03);
        cyc(2);
        `CHK({short_irq, long_irq}, 2'h3)
        xfer(`TECM_ADDR_INT_CTRL, 1'b1, 32'h33);
        xfer(`TECM_ADDR_INT_CTRL, 1'b0, 32'h03);
        `CHK({short_irq, long_irq}, 2'h0)
        xfer(`TECM_ADDR_INT_CTRL, 1'b1, 32'h00);
        // Event counting in power-down: one extra rise, then five short pulses
        power_down <= 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            for (int e = 0; e < 2; e++) begin
                xfer(ca(ch), 1'b1, cv(8'h40, e));
                ld(ch, 16'hfffc);
                xfer(ca(ch), 1'b1, cv(8'h50, e));
                pull_chk;
                idle <= 2'h3;
                cyc(8);
                burst(ch);
                xfer(ca(ch), 1'b0, cv(8'h50, e));
                xfer(ca(ch), 1'b1, cv(8'h40, e));
                rd_cnt(ch, e ? 16'hfffd : 16'hfffe);
                `CHK(wakes, ch * 2 + e + 1)
                idle <= 2'h0;
                cyc(8);
            end
        end
        power_down <= 1'b0;
        xfer(`TECM_ADDR_INT_CTRL, 1'b1, 32'h30);
        // Pulse width: 40-cycle pulse is ten ticks; second pulse ignored
        width <= 8'h28;
        pulses <= 8'h01;
        idle <= 2'h3;
        cyc(8);
        for (int ch = 0; ch < 2; ch++) begin
            for (int e = 0; e < 2; e++) begin
                xfer(ca(ch), 1'b1, cv(8'hc0, e));
                ld(ch, 16'h0000);
                xfer(ca(ch), 1'b1, cv(8'hd0, e));
                pull_chk;
                cyc(20);
                rd_cnt(ch, 16'h0000);
                idle <= e ? 2'h0 : 2'h3;
                cyc(8);
                burst(ch);
                xfer(ca(ch), 1'b0, cv(8'hc0, e));
                rd_cnt(ch, 16'h000a);
                burst(ch);
                rd_cnt(ch, 16'h000a);
                idle <= 2'h3;
                cyc(8);
            end
        end
        cyc(4);
        final_report;
    end
endmodule

// ### hdl/tecm_top.sv
// Two timer/event counters (8-bit and 16-bit) with an AHB-Lite register slave.
`include "tecm_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// One counter channel of parameterised width
module tecm_channel #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         tick,       // System clock divided by four
    input  wire logic         pin_rise,   // Synchronised pin rising edge
    input  wire logic         pin_fall,   // Synchronised pin falling edge
    input  wire logic [1:0]   mode,
    input  wire logic         run,
    input  wire logic         edge_sel,
    input  wire logic         load_en,    // Preload write strobe
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count,
    output logic              ovf,        // One-cycle overflow pulse
    output logic              done        // One-cycle end of pulse measurement
);
    // Width check: byte-wide bus access cannot serve other widths
    if (W != 8 && W != 16) begin : g_bad_width
        $error("tecm_channel width must be 8 or 16");
    end

    logic [W-1:0]       preload;          // Reload value
    tecm_pkg::tecm_pulse_e state;         // Pulse sequencer
    tecm_pkg::tecm_pulse_e next_state;

    // Mode decode
    wire is_timer = (mode == `TECM_MODE_TIMER);
    wire is_event = (mode == `TECM_MODE_EVENT);
    wire is_pulse = (mode == `TECM_MODE_PULSE);

    // Active edge select for events and pulse start
    wire act_edge  = edge_sel ? pin_fall : pin_rise;
    wire start_edg = edge_sel ? pin_rise : pin_fall;
    wire stop_edg  = edge_sel ? pin_fall : pin_rise;

    // Increment sources; pin edges are not divided in event mode
    wire inc_timer = is_timer & tick;
    wire inc_event = is_event & act_edge;
    wire inc_pulse = is_pulse & (state == tecm_pkg::TECM_MEASURE) & tick;
    wire inc       = run & (inc_timer | inc_event | inc_pulse);
    wire full      = (count == {W{1'b1}});
    wire load_now  = load_en & ~run;
    wire end_meas  = run & is_pulse & (state == tecm_pkg::TECM_MEASURE) & stop_edg;

    // Sequencer: arming on run, start on an edge only, never on a level
    always_comb begin
        case (state)
            tecm_pkg::TECM_IDLE: begin
                // Run is still high for a cycle after a shot ends; do not rearm then
                next_state = (run & is_pulse & ~done) ? tecm_pkg::TECM_ARMED : tecm_pkg::TECM_IDLE;
            end
            tecm_pkg::TECM_ARMED: begin
                if (!run || !is_pulse) begin
                    next_state = tecm_pkg::TECM_IDLE;
                end else if (start_edg) begin
                    next_state = tecm_pkg::TECM_MEASURE;
                end else begin
                    next_state = tecm_pkg::TECM_ARMED;
                end
            end
            tecm_pkg::TECM_MEASURE: begin
                // Stop edge ends the shot; run clear makes it single shot
                if (!run || !is_pulse || stop_edg) begin
                    next_state = tecm_pkg::TECM_IDLE;
                end else begin
                    next_state = tecm_pkg::TECM_MEASURE;
                end
            end
            default: begin
                next_state = tecm_pkg::TECM_IDLE;
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= tecm_pkg::TECM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Preload register, always written by a preload write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            preload <= '0;
        end else if (load_en) begin
            preload <= load_val;
        end
    end

    // Counter: stopped write loads, overflow reloads and keeps going
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            ovf   <= 1'b0;
        end else begin
            ovf <= inc & full & ~load_now;
            if (load_now) begin
                count <= load_val;
            end else if (inc && full) begin
                count <= preload;
            end else if (inc) begin
                count <= W'(count + 1'b1);
            end
        end
    end

    // End of measurement pulse towards run bit clearing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= end_meas;
        end
    end

    // Checks on counting behaviour
    AST_TIMER_TICK: assert property (@(posedge core_clk) disable iff (rst)
        run && is_timer && tick && !load_en && !full |=> count == W'($past(count) + 1'b1))
        else $error("timer mode did not count a divided clock tick");
    AST_EVENT_EDGE: assert property (@(posedge core_clk) disable iff (rst)
        run && is_event && !edge_sel && pin_rise && !load_en && !full |=> count == W'($past(count) + 1'b1))
        else $error("event mode missed a rising edge");
    AST_HALT: assert property (@(posedge core_clk) disable iff (rst)
        !run && !load_en |=> count == $past(count))
        else $error("counter moved while halted");
    AST_OVF_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
        inc && full && !load_en |=> ovf && count == $past(preload))
        else $error("overflow did not reload and flag");
    AST_ARMED_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        state == tecm_pkg::TECM_ARMED && !load_en ##1 state == tecm_pkg::TECM_ARMED |-> count == $past(count))
        else $error("armed counter counted before an edge");
    AST_PULSE_END: assert property (@(posedge core_clk) disable iff (rst)
        end_meas |=> done && state == tecm_pkg::TECM_IDLE)
        else $error("pulse end not taken");
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: bus slave, pin synchronisers, control registers, two channels
module tecm_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // Timer pins (shared I/O, configured as inputs)
    input  wire logic        short_count_pin,
    input  wire logic        long_count_pin,
    input  wire logic [1:0]  pullup_select,   // Port pull-high options
    output logic      [1:0]  pullup_enable,
    // Power state and interrupt outputs
    input  wire logic        power_down,
    output logic             short_irq,
    output logic             long_irq,
    output logic             wake_up
);
    logic [7:0]  short_counter_control;   // Short counter control
    logic [7:0]  long_counter_control;    // Long counter control
    logic [7:0]  int_control;             // Enables and request flags
    logic [7:0]  low_wr_buf;              // Long low byte write holding buffer
    logic [7:0]  low_rd_buf;              // Long low byte read latch
    logic [1:0]  prescale;                // Divide by four
    logic        tick;
    logic [1:0]  pin_s1;                  // Synchroniser first stage
    logic [1:0]  pin_s2;                  // Synchroniser second stage
    logic [1:0]  pin_s3;                  // Previous synchronised sample
    logic        dp_write;                // Pending write data phase
    logic [7:0]  dp_addr;
    logic [7:0]  short_count;
    logic [15:0] long_count;
    logic        short_ovf;
    logic        long_ovf;
    logic        short_done;
    logic        long_done;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire         addr_ok  = hsel & htrans[`TECM_HTRANS_ACTIVE] & hready;
    wire         rd_take  = addr_ok & ~hwrite;
    wire         wr_take  = addr_ok & hwrite;
    wire         wr_sctl  = dp_write & (dp_addr == `TECM_ADDR_SHORT_CTRL);
    wire         wr_scnt  = dp_write & (dp_addr == `TECM_ADDR_SHORT_COUNT);
    wire         wr_lctl  = dp_write & (dp_addr == `TECM_ADDR_LONG_CTRL);
    wire         wr_llow  = dp_write & (dp_addr == `TECM_ADDR_LONG_LOW);
    wire         wr_lhigh = dp_write & (dp_addr == `TECM_ADDR_LONG_HIGH);
    wire         wr_int   = dp_write & (dp_addr == `TECM_ADDR_INT_CTRL);
    wire         rd_lhigh = rd_take & (haddr == `TECM_ADDR_LONG_HIGH);
    wire  [7:0]  wbyte    = hwdata[7:0];
    wire  [15:0] long_load = {wbyte, low_wr_buf};

    // Read mux; unmapped addresses read zero
    wire  [7:0]  rd_byte =
        (haddr == `TECM_ADDR_SHORT_CTRL)  ? short_counter_control :
        (haddr == `TECM_ADDR_SHORT_COUNT) ? short_count :
        (haddr == `TECM_ADDR_LONG_CTRL)   ? long_counter_control :
        (haddr == `TECM_ADDR_LONG_LOW)    ? low_rd_buf :
        (haddr == `TECM_ADDR_LONG_HIGH)   ? long_count[15:8] :
        (haddr == `TECM_ADDR_INT_CTRL)    ? int_control : 8'h00;

    // Address phase capture; zero wait states, always OKAY
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dp_write  <= 1'b0;
            dp_addr   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp_write  <= wr_take;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok) begin
                dp_addr <= haddr;
            end
            if (rd_take) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection on settled samples
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_s3 <= 2'h0;
        end else begin
            pin_s1 <= {long_count_pin, short_count_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    wire  [1:0]  pin_rise = pin_s2 & ~pin_s3;
    wire  [1:0]  pin_fall = ~pin_s2 & pin_s3;

    // Divide by four tick shared by both channels
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prescale <= 2'h0;
            tick     <= 1'b0;
        end else begin
            prescale <= 2'(prescale + 1'b1);
            tick     <= (prescale == `TECM_PRESCALE_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; software write beats auto clear, only pulse ends clear run
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            short_counter_control <= `TECM_CTRL_RESET;
            long_counter_control  <= `TECM_CTRL_RESET;
        end else begin
            if (wr_sctl) begin
                short_counter_control <= wbyte;
            end else if (short_done) begin
                short_counter_control[`TECM_RUN_BIT] <= 1'b0;
            end
            if (wr_lctl) begin
                long_counter_control <= wbyte;
            end else if (long_done) begin
                long_counter_control[`TECM_RUN_BIT] <= 1'b0;
            end
        end
    end

    // Long counter byte buffers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_wr_buf <= 8'h00;
            low_rd_buf <= 8'h00;
        end else begin
            if (wr_llow) begin
                low_wr_buf <= wbyte;
            end
            if (rd_lhigh) begin
                low_rd_buf <= long_count[7:0];
            end
        end
    end

    // Interrupt control: enables written, flags write-one-to-clear, set wins
    wire  [7:0]  flag_set = {2'h0, long_ovf, short_ovf, 4'h0};
    wire  [7:0]  flag_clr = wr_int ? {2'h0, wbyte[`TECM_INT_REQ_LONG:`TECM_INT_REQ_SHORT], 4'h0} : 8'h00;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_control <= 8'h00;
        end else begin
            int_control[3:0] <= wr_int ? {2'h0, wbyte[1:0]} : int_control[3:0];
            int_control[7:4] <= ((int_control[7:4] & ~flag_clr[7:4]) | flag_set[7:4]);
        end
    end

    // Gated requests, wake on overflow in power-down, pull-high kept
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            short_irq     <= 1'b0;
            long_irq      <= 1'b0;
            wake_up       <= 1'b0;
            pullup_enable <= 2'h0;
        end else begin
            short_irq     <= int_control[`TECM_INT_REQ_SHORT] & int_control[`TECM_INT_EN_SHORT];
            long_irq      <= int_control[`TECM_INT_REQ_LONG] & int_control[`TECM_INT_EN_LONG];
            wake_up       <= power_down & (short_ovf | long_ovf);
            pullup_enable <= pullup_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels; they keep counting regardless of power_down
    tecm_channel #(.W(8)) u_short (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (tick),
        .pin_rise (pin_rise[0]),
        .pin_fall (pin_fall[0]),
        .mode     (short_counter_control[`TECM_MODE_HI:`TECM_MODE_LO]),
        .run      (short_counter_control[`TECM_RUN_BIT]),
        .edge_sel (short_counter_control[`TECM_EDGE_BIT]),
        .load_en  (wr_scnt),
        .load_val (wbyte),
        .count    (short_count),
        .ovf      (short_ovf),
        .done     (short_done)
    );

    tecm_channel #(.W(16)) u_long (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (tick),
        .pin_rise (pin_rise[1]),
        .pin_fall (pin_fall[1]),
        .mode     (long_counter_control[`TECM_MODE_HI:`TECM_MODE_LO]),
        .run      (long_counter_control[`TECM_RUN_BIT]),
        .edge_sel (long_counter_control[`TECM_EDGE_BIT]),
        .load_en  (wr_lhigh),
        .load_val (long_load),
        .count    (long_count),
        .ovf      (long_ovf),
        .done     (long_done)
    );

    // Checks on top-level behaviour
    AST_RUN_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        short_done && !wr_sctl |=> !short_counter_control[`TECM_RUN_BIT])
        else $error("run bit not cleared after pulse end");
    AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (rst)
        short_irq |-> $past(int_control[`TECM_INT_EN_SHORT]))
        else $error("interrupt forwarded while disabled");
    AST_LOW_LATCH: assert property (@(posedge core_clk) disable iff (rst)
        rd_lhigh |=> low_rd_buf == $past(long_count[7:0]))
        else $error("high read did not latch low byte");
    AST_WAKE: assert property (@(posedge core_clk) disable iff (rst)
        power_down && long_ovf |=> wake_up)
        else $error("overflow in power-down did not wake");
endmodule
